// *** tcc_top.sv ***
// Purpose: Timer capture/compare block with seven channels behind an AXI4-Lite slave
// Assumes: Inputs synchronous to MCLK, synchronous active-high reset RST
// Notes: Counter runs free while enabled; two interrupt lines
//
// Functional notes
// R1: Seven channels, indexed zero to six.
// R2: Capture none, rising, falling or both edges.
// R3: Source primary, secondary, ground or supply.
// R4: Source used raw or timer-clock synchronized.
// R5: Per-channel interrupt enable, default off.
// R6: Eight output modes, static bit default.
// R7: Compare value matched against running count.
// R8: Counter and channel values sixteen bits.
// R9: Channel zero line; shared line for others.
// R10: Flags stay set until software clears.
// R11: Interrupt needs its enable in timer.
// R12: Overflow and event flags; enabled view.
// R13: Input level readable raw or synchronized.
// R14: Capture copies counter, sets flag.
// R15: Capture while flag set sets overflow.
`default_nettype none
module tcc_top (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic [6:0] CAP_IN_PRIMARY,
	input wire logic [6:0] CAP_IN_SECONDARY,
	output logic [6:0] CH_OUT,
	output logic IRQ_CHANNEL_ZERO,
	output logic IRQ_CHANNELS_ONE_TO_SIX
);
	localparam int N = tcc_pkg::NUM_CH;
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic run_ff, nxt_run; // Counter enable
	logic [15:0] cnt_ff, nxt_cnt; // R8
	logic [31:0] cfg_ff [N]; // Per-channel configuration words
	logic [31:0] nxt_cfg [N];
	logic [N-1:0] flag_ff, nxt_flag; // Channel event flags
	logic [N-1:0] ovf_ff, nxt_ovf; // Capture overflow flags
	logic wrap_ff, nxt_wrap; // Counter wrap flag
	logic [N-1:0] ien_ff, nxt_ien; // Channel interrupt enables
	logic wien_ff, nxt_wien; // Counter wrap interrupt enable
	logic [15:0] vwr [N];
	logic [N-1:0] vwe;
	logic [N-1:0] ev, cap;
	logic [15:0] val [N];
	logic [N-1:0] in_raw, in_sync, outs;
	// Bus state
	logic aw_ff, nxt_aw;
	logic [7:0] awa_ff, nxt_awa;
	logic w_ff, nxt_w;
	logic [31:0] wd_ff, nxt_wd;
	logic [3:0] ws_ff, nxt_ws;
	logic bv_ff, nxt_bv;
	logic [1:0] br_ff, nxt_br;
	logic rv_ff, nxt_rv;
	logic [31:0] rd_ff, nxt_rd;
	logic [1:0] rr_ff, nxt_rr;
	logic irq0_ff, nxt_irq0, irqx_ff, nxt_irqx;
	logic [N-1:0] cho_ff;
	// ----------------------------------------
	// Channels
	// ----------------------------------------
	// Each channel sees the shared counter and its own pair of inputs; the
	// interface carries its configuration in and its results back out.
	tcc_ch_if chif [N] ();
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gch // R1
			assign chif[g].edge_sel = cfg_ff[g][tcc_pkg::F_EDGE +: 2];
			assign chif[g].src_sel = cfg_ff[g][tcc_pkg::F_SRC +: 2]; // R3
			assign chif[g].sync_sel = cfg_ff[g][tcc_pkg::F_SYNC];
			assign chif[g].cap_mode = cfg_ff[g][tcc_pkg::F_CAPMODE];
			assign chif[g].omode = cfg_ff[g][tcc_pkg::F_OMODE +: 3];
			assign chif[g].obit = cfg_ff[g][tcc_pkg::F_OBIT];
			assign chif[g].value_wr = vwr[g];
			assign chif[g].value_we = vwe[g];
			assign ev[g] = chif[g].event_pulse;
			assign cap[g] = chif[g].capture_pulse;
			assign val[g] = chif[g].value;
			assign in_raw[g] = chif[g].in_raw;
			assign in_sync[g] = chif[g].in_sync;
			assign outs[g] = chif[g].out;
			tcc_channel u_ch (
				.clk(MCLK),
				.rst(RST),
				.count(cnt_ff),
				.in_primary(CAP_IN_PRIMARY[g]),
				.in_secondary(CAP_IN_SECONDARY[g]),
				.ch(chif[g])
			);
		end
	endgenerate
	// ----------------------------------------
	// Write channel: address and data taken in either order
	// ----------------------------------------
	logic wr_go;
	logic [7:0] ra;
	// Address and data wait in their own holding flags until both are present;
	// no new write is taken while the response waits to be accepted.
	always_comb begin
		nxt_aw = aw_ff;
		nxt_awa = awa_ff;
		nxt_w = w_ff;
		nxt_wd = wd_ff;
		nxt_ws = ws_ff;
		if (AWVALID && !aw_ff && !bv_ff) begin
			nxt_aw = 1'b1;
			nxt_awa = AWADDR;
		end
		if (WVALID && !w_ff && !bv_ff) begin
			nxt_w = 1'b1;
			nxt_wd = WDATA;
			nxt_ws = WSTRB;
		end
		wr_go = aw_ff && w_ff && !bv_ff;
		if (wr_go) begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
		end
	end
	// ----------------------------------------
	// Register file, counter and flags
	// ----------------------------------------
	// One process holds every software-visible register but the channel value words, so the software clear
	// and the hardware set of a flag are resolved in a single place.
	// The counter wraps at the top of its range and records the wrap.
	always_comb begin
		logic [7:0] a;
		logic [31:0] m;
		logic hit;
		logic [7:0] co;
		a = awa_ff;
		m = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};
		hit = 1'b0;
		co = 8'h00;
		nxt_run = run_ff;
		nxt_cnt = run_ff ? 16'(cnt_ff + 16'h0001) : cnt_ff;
		nxt_ien = ien_ff;
		nxt_wien = wien_ff;
		nxt_flag = flag_ff;
		nxt_ovf = ovf_ff;
		nxt_wrap = wrap_ff;
		nxt_br = br_ff;
		nxt_bv = bv_ff;
		vwe = '0;
		for (int i = 0; i < N; i++) begin
			nxt_cfg[i] = cfg_ff[i];
			vwr[i] = wd_ff[15:0];
		end
		// Software clears first so a same-cycle hardware set wins
		if (wr_go) begin
			hit = 1'b1;
			if (a == tcc_pkg::OFS_CTRL) begin
				nxt_run = (wd_ff[0] & m[0]) | (run_ff & ~m[0]);
			end else if (a == tcc_pkg::OFS_COUNT) begin
				nxt_cnt = (wd_ff[15:0] & m[15:0]) | (cnt_ff & ~m[15:0]);
			end else if (a == tcc_pkg::OFS_CLEAR) begin
				nxt_flag = flag_ff & ~(wd_ff[N-1:0] & m[N-1:0]); // R10
				nxt_ovf = ovf_ff & ~(wd_ff[tcc_pkg::ST_OVF_BASE +: N]
					& m[tcc_pkg::ST_OVF_BASE +: N]);
				nxt_wrap = wrap_ff & ~(wd_ff[tcc_pkg::ST_WRAP] & m[tcc_pkg::ST_WRAP]);
			end else if (a == tcc_pkg::OFS_ENABLE) begin
				nxt_ien = (wd_ff[N-1:0] & m[N-1:0]) | (ien_ff & ~m[N-1:0]); // R5
				nxt_wien = (wd_ff[tcc_pkg::ST_WRAP] & m[tcc_pkg::ST_WRAP])
					| (wien_ff & ~m[tcc_pkg::ST_WRAP]);
			end else begin
				hit = 1'b0;
				for (int i = 0; i < N; i++) begin
					co = 8'(tcc_pkg::OFS_CH_BASE + 8'(i) * tcc_pkg::OFS_CH_STEP);
					if (a == 8'(co + tcc_pkg::OFS_CH_CFG)) begin
						hit = 1'b1;
						nxt_cfg[i][15:0] = (wd_ff[15:0] & m[15:0]) | (cfg_ff[i][15:0] & ~m[15:0]);
					end
					if (a == 8'(co + tcc_pkg::OFS_CH_VAL)) begin
						hit = 1'b1;
						vwe[i] = 1'b1; // R7
						vwr[i] = (wd_ff[15:0] & m[15:0]) | (val[i] & ~m[15:0]);
					end
				end
			end
			nxt_bv = 1'b1;
			nxt_br = hit ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end else if (bv_ff && BREADY) begin
			nxt_bv = 1'b0;
		end
		// Hardware sets
		for (int i = 0; i < N; i++) begin
			if (cap[i] && flag_ff[i]) begin
				nxt_ovf[i] = 1'b1; // R15
			end
		end
		nxt_flag = nxt_flag | ev; // R14
		if (run_ff && cnt_ff == 16'hFFFF) begin
			nxt_wrap = 1'b1;
		end
		// The lines are registered, so they lag their flag by one edge
		// Interrupt lines gated by in-timer enables
		nxt_irq0 = flag_ff[0] & ien_ff[0]; // R9 R11
		nxt_irqx = |(flag_ff[N-1:1] & ien_ff[N-1:1]) | (wrap_ff & wien_ff); // R9 R11
	end
	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Reads are answered one edge after the address is taken; a flag that sets
	// in that same cycle shows up on the next read, not on this one.
	always_comb begin
		logic [7:0] co;
		nxt_rv = rv_ff;
		nxt_rd = rd_ff;
		nxt_rr = rr_ff;
		co = 8'h00;
		ra = ARADDR;
		if (ARVALID && !rv_ff) begin
			nxt_rv = 1'b1;
			nxt_rr = tcc_pkg::RESP_OKAY;
			nxt_rd = 32'h0000_0000;
			if (ra == tcc_pkg::OFS_CTRL) begin
				nxt_rd[0] = run_ff;
			end else if (ra == tcc_pkg::OFS_COUNT) begin
				nxt_rd[15:0] = cnt_ff;
			end else if (ra == tcc_pkg::OFS_STATUS) begin
				nxt_rd[N-1:0] = flag_ff;
				nxt_rd[tcc_pkg::ST_OVF_BASE +: N] = ovf_ff;
				nxt_rd[tcc_pkg::ST_WRAP] = wrap_ff;
			end else if (ra == tcc_pkg::OFS_ENABLE) begin
				nxt_rd[N-1:0] = ien_ff;
				nxt_rd[tcc_pkg::ST_WRAP] = wien_ff;
			end else if (ra == tcc_pkg::OFS_ENSTAT) begin
				nxt_rd[N-1:0] = flag_ff & ien_ff; // R12
				nxt_rd[tcc_pkg::ST_OVF_BASE +: N] = ovf_ff & ien_ff; // R12
				nxt_rd[tcc_pkg::ST_WRAP] = wrap_ff & wien_ff;
			end else if (ra == tcc_pkg::OFS_CLEAR) begin
				nxt_rd = 32'h0000_0000; // Write-only, reads zero
			end else begin
				nxt_rr = tcc_pkg::RESP_SLVERR;
				for (int i = 0; i < N; i++) begin
					co = 8'(tcc_pkg::OFS_CH_BASE + 8'(i) * tcc_pkg::OFS_CH_STEP);
					if (ra == 8'(co + tcc_pkg::OFS_CH_CFG)) begin
						nxt_rr = tcc_pkg::RESP_OKAY;
						nxt_rd[15:0] = cfg_ff[i][15:0];
						nxt_rd[tcc_pkg::F_IN_RAW] = in_raw[i]; // R13
						nxt_rd[tcc_pkg::F_IN_SYNC] = in_sync[i]; // R13
						nxt_rd[tcc_pkg::F_OUT] = outs[i];
					end
					if (ra == 8'(co + tcc_pkg::OFS_CH_VAL)) begin
						nxt_rr = tcc_pkg::RESP_OKAY;
						nxt_rd[15:0] = val[i];
					end
				end
			end
		end else if (rv_ff && RREADY) begin
			nxt_rv = 1'b0;
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Plain register stage; every next value comes from the processes above.
	// Channel outputs are registered once more so every top output leaves a flop.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			run_ff <= 1'b0;
			cnt_ff <= tcc_pkg::CNT_RST;
			for (int i = 0; i < N; i++) begin
				cfg_ff[i] <= tcc_pkg::CFG_RST;
			end
			flag_ff <= '0;
			ovf_ff <= '0;
			wrap_ff <= 1'b0;
			ien_ff <= '0;
			wien_ff <= 1'b0;
			aw_ff <= 1'b0;
			awa_ff <= 8'h00;
			w_ff <= 1'b0;
			wd_ff <= 32'h0000_0000;
			ws_ff <= 4'h0;
			bv_ff <= 1'b0;
			br_ff <= tcc_pkg::RESP_OKAY;
			rv_ff <= 1'b0;
			rd_ff <= 32'h0000_0000;
			rr_ff <= tcc_pkg::RESP_OKAY;
			irq0_ff <= 1'b0;
			irqx_ff <= 1'b0;
			cho_ff <= '0;
		end else begin
			run_ff <= nxt_run;
			cnt_ff <= nxt_cnt;
			for (int i = 0; i < N; i++) begin
				cfg_ff[i] <= nxt_cfg[i];
			end
			flag_ff <= nxt_flag;
			ovf_ff <= nxt_ovf;
			wrap_ff <= nxt_wrap;
			ien_ff <= nxt_ien;
			wien_ff <= nxt_wien;
			aw_ff <= nxt_aw;
			awa_ff <= nxt_awa;
			w_ff <= nxt_w;
			wd_ff <= nxt_wd;
			ws_ff <= nxt_ws;
			bv_ff <= nxt_bv;
			br_ff <= nxt_br;
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
			rr_ff <= nxt_rr;
			irq0_ff <= nxt_irq0;
			irqx_ff <= nxt_irqx;
			cho_ff <= outs;
		end
	end
	// Ready strobes come from the holding flags so outputs stay registered
	assign AWREADY = ~aw_ff & ~bv_ff;
	assign WREADY = ~w_ff & ~bv_ff;
	assign ARREADY = ~rv_ff;
	assign BVALID = bv_ff;
	assign BRESP = br_ff;
	assign RVALID = rv_ff;
	assign RDATA = rd_ff;
	assign RRESP = rr_ff;
	assign CH_OUT = cho_ff; // R6
	assign IRQ_CHANNEL_ZERO = irq0_ff;
	assign IRQ_CHANNELS_ONE_TO_SIX = irqx_ff;
endmodule : tcc_top
`default_nettype wire

// *** tcc_pkg.sv ***
// Purpose: Shared constants and types for the timer capture/compare channels
// Assumes: One clock domain, synchronous active-high reset
// Notes: Register offsets are byte addresses on a 32-bit register bus
`default_nettype none
package tcc_pkg;
	localparam int NUM_CH = 7;
	localparam int CNT_W = 16;
	localparam int AW = 8;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CLEAR = 8'h0C;
	localparam logic [7:0] OFS_ENABLE = 8'h10;
	localparam logic [7:0] OFS_ENSTAT = 8'h14;
	localparam logic [7:0] OFS_CH_BASE = 8'h20;
	localparam logic [7:0] OFS_CH_CFG = 8'h00;
	localparam logic [7:0] OFS_CH_VAL = 8'h04;
	localparam logic [7:0] OFS_CH_STEP = 8'h08;
	// ----------------------------------------
	// Channel configuration field positions
	// ----------------------------------------
	localparam int F_EDGE = 0;
	localparam int F_SRC = 2;
	localparam int F_SYNC = 4;
	localparam int F_CAPMODE = 5;
	localparam int F_OMODE = 6;
	localparam int F_OBIT = 9;
	localparam int F_IN_RAW = 16;
	localparam int F_IN_SYNC = 17;
	localparam int F_OUT = 18;
	// Status bit positions: per channel flag 0..6, overflow flags 8..14, counter wrap 16
	localparam int ST_OVF_BASE = 8;
	localparam int ST_WRAP = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Capture edge, source and output modes in hardware encoding
	typedef enum logic [1:0] {
		EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH
	} tcc_edge_t;
	typedef enum logic [1:0] {
		SRC_PRIMARY, SRC_SECONDARY, SRC_GROUND, SRC_SUPPLY
	} tcc_src_t;
	typedef enum logic [2:0] {
		OM_STATIC, OM_SET, OM_TOG_RST, OM_SET_RST, OM_TOG, OM_RST, OM_TOG_SET, OM_RST_SET
	} tcc_omode_t;
endpackage : tcc_pkg
`default_nettype wire

// *** tcc_ch_if.sv ***
// Purpose: Carries one channel's configuration and events between top and channel
// Assumes: Single clock domain
// Notes: Top drives config, channel drives results
`default_nettype none
interface tcc_ch_if;
	logic [1:0] edge_sel;
	logic [1:0] src_sel;
	logic sync_sel;
	logic cap_mode;
	logic [2:0] omode;
	logic obit;
	logic [15:0] value_wr;
	logic value_we;
	logic [15:0] value;
	logic event_pulse;
	logic capture_pulse;
	logic in_raw;
	logic in_sync;
	logic out;
	// Control side
	modport ctl (output edge_sel, src_sel, sync_sel, cap_mode, omode, obit, value_wr, value_we,
		input value, event_pulse, capture_pulse, in_raw, in_sync, out);
	// Channel side
	modport chn (input edge_sel, src_sel, sync_sel, cap_mode, omode, obit, value_wr, value_we,
		output value, event_pulse, capture_pulse, in_raw, in_sync, out);
endinterface : tcc_ch_if
`default_nettype wire

// *** tcc_channel.sv ***
// Purpose: One capture/compare channel: edge capture, compare match, output unit
// Assumes: Counter and inputs synchronous to clk
// Notes: "Asynchronous" source use means the raw level feeds the edge detector directly
`default_nettype none
module tcc_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] count,
	input wire logic in_primary,
	input wire logic in_secondary,
	tcc_ch_if.chn ch
);
	logic src_raw;
	logic meta_ff, nxt_meta;
	logic sync_ff, nxt_sync;
	logic prev_ff, nxt_prev;
	logic [15:0] val_ff, nxt_val;
	logic out_ff, nxt_out;
	logic sel_lvl;
	logic rise, fall, cap_hit, cmp_hit;
	// Source mux
	always_comb begin
		case (ch.src_sel)
			tcc_pkg::SRC_PRIMARY: src_raw = in_primary;
			tcc_pkg::SRC_SECONDARY: src_raw = in_secondary;
			tcc_pkg::SRC_GROUND: src_raw = 1'b0;
			default: src_raw = 1'b1;
		endcase
	end
	// Edge detect, capture and compare
	always_comb begin
		nxt_meta = src_raw;
		nxt_sync = meta_ff;
		sel_lvl = ch.sync_sel ? sync_ff : src_raw; // R4
		nxt_prev = sel_lvl;
		rise = sel_lvl & ~prev_ff;
		fall = ~sel_lvl & prev_ff;
		case (ch.edge_sel) // R2
			tcc_pkg::EDGE_RISE: cap_hit = rise;
			tcc_pkg::EDGE_FALL: cap_hit = fall;
			tcc_pkg::EDGE_BOTH: cap_hit = rise | fall;
			default: cap_hit = 1'b0;
		endcase
		cap_hit = cap_hit & ch.cap_mode;
		cmp_hit = ~ch.cap_mode & (count == val_ff); // R7
		nxt_val = val_ff;
		if (ch.value_we) begin
			nxt_val = ch.value_wr;
		end
		if (cap_hit) begin
			nxt_val = count; // R14
		end
	end
	// Output unit: event is capture or match; the period-boundary half uses counter zero
	always_comb begin
		logic ev;
		logic zero;
		ev = cap_hit | cmp_hit;
		zero = (count == 16'h0000);
		nxt_out = out_ff;
		case (ch.omode) // R6
			tcc_pkg::OM_STATIC: nxt_out = ch.obit;
			tcc_pkg::OM_SET: nxt_out = ev ? 1'b1 : out_ff;
			tcc_pkg::OM_TOG_RST: nxt_out = ev ? ~out_ff : (zero ? 1'b0 : out_ff);
			tcc_pkg::OM_SET_RST: nxt_out = ev ? 1'b1 : (zero ? 1'b0 : out_ff);
			tcc_pkg::OM_TOG: nxt_out = ev ? ~out_ff : out_ff;
			tcc_pkg::OM_RST: nxt_out = ev ? 1'b0 : out_ff;
			tcc_pkg::OM_TOG_SET: nxt_out = ev ? ~out_ff : (zero ? 1'b1 : out_ff);
			default: nxt_out = ev ? 1'b0 : (zero ? 1'b1 : out_ff);
		endcase
	end
	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
			val_ff <= tcc_pkg::CNT_RST;
			out_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
			val_ff <= nxt_val;
			out_ff <= nxt_out;
		end
	end
	assign ch.value = val_ff;
	assign ch.event_pulse = cap_hit | cmp_hit;
	assign ch.capture_pulse = cap_hit;
	assign ch.in_raw = src_raw; // R13
	assign ch.in_sync = sync_ff; // R13
	assign ch.out = out_ff;
endmodule : tcc_channel
`default_nettype wire

// *** tcc_top_props.sv ***
// Purpose: Port-level checker for the capture/compare block
// Assumes: One clock MCLK, synchronous active-high RST
// Notes: Watches only the top module's ports
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module tcc_top_props (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic AWREADY,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic IRQ_CHANNEL_ZERO,
	input wire logic IRQ_CHANNELS_ONE_TO_SIX
);
	// All checks share the one timer clock
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// Response must stand until taken
	b_resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	r_data_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable({RDATA, RRESP}))
		else $error("read data dropped early");
	b_resp_done_a: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response not retired");
	r_data_done_a: assert property (RVALID && RREADY |=> !RVALID)
		else $error("read response not retired");
	// No new write accepted while a response waits
	w_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while response pending");
	r_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read answer late");
	b_code_a: assert property (BVALID |-> BRESP == tcc_pkg::RESP_OKAY || BRESP == tcc_pkg::RESP_SLVERR)
		else $error("bad write response code");
	// A line may only drop after software wrote something
	irq_zero_sticky_a: assert property ($fell(IRQ_CHANNEL_ZERO) |->
		BVALID || $past(BVALID) || $past(BVALID, 2)) else $error("line zero dropped alone");
	irq_many_sticky_a: assert property ($fell(IRQ_CHANNELS_ONE_TO_SIX) |->
		BVALID || $past(BVALID) || $past(BVALID, 2)) else $error("shared line dropped alone");
endmodule : tcc_top_props
bind tcc_top tcc_top_props u_props (.MCLK, .RST, .AWREADY, .WREADY, .BRESP, .BVALID, .BREADY,
	.ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .IRQ_CHANNEL_ZERO,
	.IRQ_CHANNELS_ONE_TO_SIX);
`default_nettype wire

// *** tcc_top_tb.sv ***
// Purpose: Self-checking bench for the capture/compare block
// Assumes: Counter stopped during capture tests so captured values are known
// Notes: Bus waits are bounded; a timeout counts as a mismatch
`default_nettype none
module tcc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic [7:0] AWADDR = 0, ARADDR = 0;
	logic [31:0] WDATA = 0, RDATA, d;
	logic [6:0] PRI = 0, SEC = 0, CH_OUT;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ0, IRQ1;
	logic [1:0] BRESP, RRESP, r;
	int n_fail = 0, checked = 0;
	tcc_top uut (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.CAP_IN_PRIMARY(PRI), .CAP_IN_SECONDARY(SEC), .CH_OUT(CH_OUT),
		.IRQ_CHANNEL_ZERO(IRQ0), .IRQ_CHANNELS_ONE_TO_SIX(IRQ1));
	// 250 MHz timer clock
	initial forever #2 MCLK = ~MCLK;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task give_verdict;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Channel register address; o selects config or value word
	function automatic logic [7:0] ca(input int i, input logic [7:0] o);
		return tcc_pkg::OFS_CH_BASE + 8'(8 * i) + o;
	endfunction : ca
	// Ready is looked at on the falling edge, so it equals what the next rising edge samples
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ra, rw, rb;
		@(posedge MCLK);
		AWADDR <= a; WDATA <= v; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
		for (int n = 0; n < 100; n++) begin
			@(negedge MCLK);
			ra = AWREADY; rw = WREADY; rb = BVALID; r = BRESP;
			@(posedge MCLK);
			if (ra) AWVALID <= 0;
			if (rw) WVALID <= 0;
			if (rb) break;
			if (n == 99) begin n_fail++; give_verdict(); end
		end
		BREADY <= 0;
		chk(32'(r), 32'(er));
	endtask : wr
	task rd(input logic [7:0] a, input logic [1:0] er);
		logic ra, rv;
		@(posedge MCLK);
		ARADDR <= a; ARVALID <= 1; RREADY <= 1;
		for (int n = 0; n < 100; n++) begin
			@(negedge MCLK);
			ra = ARREADY; rv = RVALID; d = RDATA; r = RRESP;
			@(posedge MCLK);
			if (ra) ARVALID <= 0;
			if (rv) break;
			if (n == 99) begin n_fail++; give_verdict(); end
		end
		RREADY <= 0;
		chk(32'(r), 32'(er));
	endtask : rd
	task setin(input logic [6:0] p, input logic [6:0] s);
		@(posedge MCLK);
		PRI <= p; SEC <= s;
		repeat (4) @(posedge MCLK);
	endtask : setin
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Defaults after reset, plus refused accesses
	task t_reset;
		for (int i = 0; i < 7; i++) begin
			rd(ca(i, tcc_pkg::OFS_CH_CFG), 0);
			chk(d & 32'h0000_03FF, 0);
		end
		rd(tcc_pkg::OFS_ENABLE, 0);
		chk(d, 0);
		chk({IRQ0, IRQ1}, 0);
		rd(8'hFC, tcc_pkg::RESP_SLVERR);
		wr(tcc_pkg::OFS_STATUS, 32'hFFFF_FFFF, tcc_pkg::RESP_SLVERR);
	endtask : t_reset
	// Capture copy, overflow, enabled view, shared line, clear
	task t_capture;
		wr(tcc_pkg::OFS_COUNT, 32'h0000_1234, 0);
		wr(tcc_pkg::OFS_CLEAR, 32'h0001_7F7F, 0);
		wr(ca(1, tcc_pkg::OFS_CH_CFG), 32'h0000_0021, 0);
		setin(7'h02, 0);
		rd(ca(1, tcc_pkg::OFS_CH_VAL), 0);
		chk(d & 32'h0000_FFFF, 32'h0000_1234);
		rd(tcc_pkg::OFS_STATUS, 0);
		chk(d & 32'h0000_0202, 32'h0000_0002);
		setin(0, 0);
		setin(7'h02, 0);
		rd(tcc_pkg::OFS_STATUS, 0);
		chk(d & 32'h0000_0202, 32'h0000_0202);
		rd(tcc_pkg::OFS_ENSTAT, 0);
		chk(d, 0);
		chk(32'(IRQ1), 0);
		wr(tcc_pkg::OFS_ENABLE, 32'h0000_0002, 0);
		rd(tcc_pkg::OFS_ENSTAT, 0);
		chk(d & 32'h0000_0202, 32'h0000_0202);
		repeat (20) @(posedge MCLK);
		chk({IRQ0, IRQ1}, 1);
		wr(tcc_pkg::OFS_CLEAR, 32'h0000_0202, 0);
		repeat (3) @(posedge MCLK);
		chk(32'(IRQ1), 0);
		wr(tcc_pkg::OFS_ENABLE, 0, 0);
	endtask : t_capture
	// Every edge setting against a rise and a fall
	task t_edges;
		for (int e = 0; e < 4; e++) begin
			wr(ca(2, tcc_pkg::OFS_CH_CFG), 32'h0000_0020 | e, 0);
			setin(7'h04, 0);
			rd(tcc_pkg::OFS_STATUS, 0);
			chk(32'(d[2]), 32'(e == 1 || e == 3));
			wr(tcc_pkg::OFS_CLEAR, 32'h0000_0404, 0);
			setin(0, 0);
			rd(tcc_pkg::OFS_STATUS, 0);
			chk(32'(d[2]), 32'(e >= 2));
			wr(tcc_pkg::OFS_CLEAR, 32'h0000_0404, 0);
		end
	endtask : t_edges
	// Source select, secondary capture, synced level
	task t_sources;
		setin(7'h08, 0);
		for (int s = 0; s < 4; s++) begin
			wr(ca(3, tcc_pkg::OFS_CH_CFG), 32'h0000_0020 | (s << 2), 0);
			rd(ca(3, tcc_pkg::OFS_CH_CFG), 0);
			chk(32'(d[16]), 32'(s == 0 || s == 3));
		end
		wr(ca(3, tcc_pkg::OFS_CH_CFG), 32'h0000_0025, 0);
		setin(7'h08, 7'h08);
		rd(tcc_pkg::OFS_STATUS, 0);
		chk(32'(d[3]), 1);
		wr(ca(3, tcc_pkg::OFS_CH_CFG), 32'h0000_0031, 0);
		rd(ca(3, tcc_pkg::OFS_CH_CFG), 0);
		chk(32'(d[17]), 1);
		setin(0, 0);
		rd(ca(3, tcc_pkg::OFS_CH_CFG), 0);
		chk(32'(d[17]), 0);
		wr(tcc_pkg::OFS_CLEAR, 32'h0001_7F7F, 0);
	endtask : t_sources
	// Compare match on channel zero through all eight output modes
	task t_compare;
		logic [2:0] m[8] = '{0, 1, 5, 4, 2, 3, 6, 7};
		logic x[8] = '{1, 1, 0, 1, 1, 1, 0, 0};
		wr(tcc_pkg::OFS_ENABLE, 32'h0000_0001, 0);
		wr(ca(0, tcc_pkg::OFS_CH_VAL), 32'h0000_0010, 0);
		for (int k = 0; k < 8; k++) begin
			wr(tcc_pkg::OFS_CTRL, 0, 0);
			wr(tcc_pkg::OFS_COUNT, 0, 0);
			wr(ca(0, tcc_pkg::OFS_CH_CFG), 32'h0000_0200 | (32'(m[k]) << 6), 0);
			wr(tcc_pkg::OFS_CTRL, 1, 0);
			repeat (40) @(posedge MCLK);
			chk(32'(CH_OUT[0]), 32'(x[k]));
		end
		wr(tcc_pkg::OFS_CTRL, 0, 0);
		rd(tcc_pkg::OFS_STATUS, 0);
		chk(32'(d[0]), 1);
		chk({IRQ0, IRQ1}, 2);
		wr(tcc_pkg::OFS_CLEAR, 32'h0000_0001, 0);
		repeat (3) @(posedge MCLK);
		chk(32'(IRQ0), 0);
	endtask : t_compare
	// Main sequence
	initial begin
		repeat (12) @(posedge MCLK);
		RST <= 0;
		t_reset();
		t_capture();
		t_edges();
		t_sources();
		t_compare();
		give_verdict();
	end
endmodule : tcc_top_tb
`default_nettype wire
